//--- src/amis_irq.sv
// Raw and masked interrupt status of the asynchronous memory port.
// Assumes a classic Wishbone master and wait pins from outside the clock domain.
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
module amis_irq (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [amis_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [amis_pkg::DATA_W-1:0] wb_dat_i,
    output logic [amis_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [amis_pkg::PIN_W-1:0] memory_wait_input,
    input wire logic ext_wait_stall,
    output logic irq_pulse,
    output logic irq_level
);

    localparam int FW = amis_pkg::FLAG_W;
    localparam int DW = amis_pkg::DATA_W;
    localparam int CW = amis_pkg::COUNT_W;
    localparam int PW = amis_pkg::PIN_W;

    // Wait pin synchronisers
    logic [PW-1:0] wait_sync1_reg;
    logic [PW-1:0] wait_sync2_reg;
    logic [PW-1:0] wait_prev_reg;
    logic [PW-1:0] wait_rise;

    // Status and control state
    logic [FW-1:0] raw_reg;
    logic [FW-1:0] raw_next;
    logic [FW-1:0] masked_reg;
    logic [FW-1:0] masked_next;
    logic [FW-1:0] enable_reg;
    logic [FW-1:0] enable_next;
    logic [CW-1:0] max_ext_wait_count_reg;
    logic [CW-1:0] max_ext_wait_count_next;
    logic [FW-1:0] event_status_reg;
    logic [FW-1:0] event_status_next;
    logic [FW-1:0] event_mask_reg;
    logic [FW-1:0] event_mask_next;
    logic irq_pulse_reg;
    logic irq_pulse_next;
    logic irq_level_reg;
    logic irq_level_next;

    // Bus slave state
    logic ack_reg;
    logic ack_next;
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;

    // Decode and events
    logic req;
    logic wr;
    logic rd;
    logic [FW-1:0] wr_flags;
    logic [FW-1:0] clear_flags;
    logic [FW-1:0] events;
    logic [FW-1:0] new_masked;
    logic timeout_event;

    // Pin synchroniser; the first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wait_sync1_reg <= '0;
            wait_sync2_reg <= '0;
            wait_prev_reg <= '0;
        end
        else
        begin
            wait_sync1_reg <= memory_wait_input;
            wait_sync2_reg <= wait_sync1_reg;
            wait_prev_reg <= wait_sync2_reg;
        end
    end

    // Rising edge from the last two synchronised samples
    genvar g;
    generate
        for (g = 0; g < PW; g = g + 1)
        begin : gen_rise
            assign wait_rise[g] = wait_sync2_reg[g] & ~wait_prev_reg[g];
        end
    endgenerate

    amis_wait_timer #(
        .COUNT_W(CW)
    ) u_wait_timer (
        .clk(clk),
        .rst(rst),
        .stall(ext_wait_stall),
        .limit(max_ext_wait_count_reg),
        .expire(timeout_event)
    );

    // Event vector in flag layout; bit 1 has no source
    always_comb
    begin
        events = '0;
        events[amis_pkg::WAIT5_BIT] = wait_rise[amis_pkg::PIN5_LANE];
        events[amis_pkg::WAIT4_BIT] = wait_rise[amis_pkg::PIN4_LANE];
        events[amis_pkg::WAIT3_BIT] = wait_rise[amis_pkg::PIN3_LANE];
        events[amis_pkg::WAIT0_BIT] = wait_rise[amis_pkg::PIN0_LANE];
        events[amis_pkg::TIMEOUT_BIT] = timeout_event;
    end

    // Bus decode: a request is acted on in the cycle before its ack
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = req & wb_we_i;
    assign rd = req & ~wb_we_i;
    // Flags live in byte lane 0 only; other lanes carry nothing to write
    assign wr_flags = wb_sel_i[0] ? wb_dat_i[FW-1:0] & amis_pkg::FLAG_IMPL : '0;

    // Write-one clears from either status word
    always_comb
    begin
        clear_flags = '0;
        if (wr && (wb_adr_i == amis_pkg::RAW_STATUS_ADDR ||
                   wb_adr_i == amis_pkg::MASKED_STATUS_ADDR))
        begin
            clear_flags = wr_flags;
        end
    end

    // Enables and timeout count
    always_comb
    begin
        enable_next = enable_reg;
        max_ext_wait_count_next = max_ext_wait_count_reg;
        event_mask_next = event_mask_reg;
        if (wr)
        begin
            case (wb_adr_i)
                amis_pkg::ENABLE_SET_ADDR:
                begin
                    enable_next = enable_reg | wr_flags;
                end
                amis_pkg::ENABLE_CLEAR_ADDR:
                begin
                    enable_next = enable_reg & ~wr_flags;
                end
                amis_pkg::WAIT_CFG_ADDR:
                begin
                    if (wb_sel_i[0])
                    begin
                        max_ext_wait_count_next = wb_dat_i[CW-1:0];
                    end
                end
                amis_pkg::EVENT_MASK_ADDR:
                begin
                    event_mask_next = wr_flags;
                end
                default:
                begin
                    enable_next = enable_reg;
                end
            endcase
        end
    end

    // Raw and masked flags; an event beats a clear in the same cycle
    always_comb
    begin
        raw_next = ((raw_reg & ~clear_flags) | events) & amis_pkg::FLAG_IMPL;
        new_masked = events & enable_reg;
        // Disabling a source drops its masked copy so it reads 0
        masked_next = ((masked_reg & ~clear_flags) | new_masked) & enable_next;
        irq_pulse_next = |(new_masked & ~masked_reg);
    end

    // Sticky event status, cleared by reading it; a new event still lands
    always_comb
    begin
        event_status_next = event_status_reg;
        if (rd && wb_adr_i == amis_pkg::EVENT_STATUS_ADDR)
        begin
            event_status_next = '0;
        end
        event_status_next = event_status_next | events;
        irq_level_next = |(event_status_next & event_mask_next);
    end

    // Read data and ack, both registered
    always_comb
    begin
        ack_next = req;
        rdata_next = amis_pkg::UNMAPPED_READ;
        if (rd)
        begin
            case (wb_adr_i)
                amis_pkg::RAW_STATUS_ADDR:
                begin
                    rdata_next[FW-1:0] = raw_reg;
                end
                amis_pkg::MASKED_STATUS_ADDR:
                begin
                    rdata_next[FW-1:0] = masked_reg & enable_reg;
                end
                amis_pkg::ENABLE_SET_ADDR,
                amis_pkg::ENABLE_CLEAR_ADDR:
                begin
                    rdata_next[FW-1:0] = enable_reg;
                end
                amis_pkg::WAIT_CFG_ADDR:
                begin
                    rdata_next[CW-1:0] = max_ext_wait_count_reg;
                end
                amis_pkg::EVENT_STATUS_ADDR:
                begin
                    rdata_next[FW-1:0] = event_status_reg;
                end
                amis_pkg::EVENT_MASK_ADDR:
                begin
                    rdata_next[FW-1:0] = event_mask_reg;
                end
                default:
                begin
                    // Unmapped words still ack, reading zero
                    rdata_next = amis_pkg::UNMAPPED_READ;
                end
            endcase
        end
    end

    // Flag registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            raw_reg <= amis_pkg::FLAG_RESET;
            masked_reg <= amis_pkg::FLAG_RESET;
            irq_pulse_reg <= 1'b0;
        end
        else
        begin
            raw_reg <= raw_next;
            masked_reg <= masked_next;
            irq_pulse_reg <= irq_pulse_next;
        end
    end

    // Control registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enable_reg <= amis_pkg::FLAG_RESET;
            max_ext_wait_count_reg <= amis_pkg::WAIT_COUNT_RESET;
            event_mask_reg <= amis_pkg::FLAG_RESET;
        end
        else
        begin
            enable_reg <= enable_next;
            max_ext_wait_count_reg <= max_ext_wait_count_next;
            event_mask_reg <= event_mask_next;
        end
    end

    // Sticky status and level output
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            event_status_reg <= amis_pkg::FLAG_RESET;
            irq_level_reg <= 1'b0;
        end
        else
        begin
            event_status_reg <= event_status_next;
            irq_level_reg <= irq_level_next;
        end
    end

    // Bus slave registers; data is zero whenever ack is low
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= amis_pkg::UNMAPPED_READ;
        end
        else
        begin
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign irq_pulse = irq_pulse_reg;
    assign irq_level = irq_level_reg;

endmodule : amis_irq

//--- inc/amis_pkg.sv
// Constants of the wait-edge and timeout interrupt status block.
// Assumes a 32-bit classic Wishbone register bus and a 250 MHz clock.
package amis_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int FLAG_W = 6;
    localparam int COUNT_W = 8;

    // Byte addresses of the register words
    localparam logic [ADDR_W-1:0] RAW_STATUS_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] MASKED_STATUS_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] ENABLE_SET_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] ENABLE_CLEAR_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] WAIT_CFG_ADDR = 8'h10;
    localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 8'h14;
    localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 8'h18;

    // Flag positions, shared by raw, masked, enable, event status and mask words
    localparam int WAIT5_BIT = 5;
    localparam int WAIT4_BIT = 4;
    localparam int WAIT3_BIT = 3;
    localparam int WAIT0_BIT = 2;
    localparam int TIMEOUT_BIT = 0;
    localparam logic [FLAG_W-1:0] FLAG_IMPL = 6'h3D;

    // Wait input lanes inside the four-bit wait port
    localparam int PIN5_LANE = 3;
    localparam int PIN4_LANE = 2;
    localparam int PIN3_LANE = 1;
    localparam int PIN0_LANE = 0;
    localparam int PIN_W = 4;

    // Reset values
    localparam logic [FLAG_W-1:0] FLAG_RESET = 6'h00;
    localparam logic [COUNT_W-1:0] WAIT_COUNT_RESET = 8'h80;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;

endpackage : amis_pkg

//--- src/amis_wait_timer.sv
// Extended-wait timeout counter.
// Assumes the stall input comes from the access sequencer on the same clock.
`timescale 1ns/10ps
module amis_wait_timer #(
    parameter int COUNT_W = amis_pkg::COUNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic [COUNT_W-1:0] limit,
    output logic expire
);

    logic [COUNT_W-1:0] count_reg;
    logic [COUNT_W-1:0] count_next;
    logic fired_reg;
    logic fired_next;
    logic expire_reg;
    logic expire_next;

    always_comb
    begin
        count_next = count_reg;
        fired_next = fired_reg;
        expire_next = 1'b0;
        if (!stall)
        begin
            count_next = '0;
            fired_next = 1'b0;
        end
        else if (!fired_reg)
        begin
            // One flag per stall, however long the wait input stays stuck
            if (count_reg >= limit)
            begin
                expire_next = 1'b1;
                fired_next = 1'b1;
            end
            else
            begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_reg <= '0;
            fired_reg <= 1'b0;
            expire_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            fired_reg <= fired_next;
            expire_reg <= expire_next;
        end
    end

    assign expire = expire_reg;

endmodule : amis_wait_timer

//--- sim/amis_irq_checker.sv
// Port checker of the interrupt status block.
// Assumes only the top module's ports; bound at the foot.
`timescale 1ns/10ps
module amis_irq_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [3:0] memory_wait_input,
    input wire logic ext_wait_stall,
    input wire logic irq_pulse,
    input wire logic irq_level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack_time;
        s_req |=> s_ack_once;
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("ack timing wrong");
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_idle_data;
        !wb_ack_o |-> wb_dat_o == 32'h00000000;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("data without ack");
    property p_reserved;
        wb_ack_o && wb_adr_i != 8'h10 |-> wb_dat_o[31:6] == 26'h0 && !wb_dat_o[1];
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_unmapped;
        wb_ack_o && $past(!wb_we_i && wb_adr_i > 8'h18) |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    // Pins are slow; bench holds them several cycles
    property p_pulse_cause;
        irq_pulse |-> $past(memory_wait_input != 4'h0, 3) || $past(ext_wait_stall, 2)
            || $past(ext_wait_stall);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without event");
    property p_reset_out;
        $fell(rst) |-> !wb_ack_o && !irq_pulse && !irq_level;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs after reset");
    property p_level_drop;
        $fell(irq_level) |-> wb_ack_o;
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("level fell alone");
endmodule : amis_irq_checker
bind amis_irq amis_irq_checker amis_irq_checker_inst (.clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .memory_wait_input,
    .ext_wait_stall, .irq_pulse, .irq_level);

//--- sim/amis_irq_sink.sv
// Counting stand-in for the CPU interrupt controller.
// Assumes one-cycle high requests on the block's clock.
`timescale 1ns/10ps
module amis_irq_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq_pulse,
    output logic [7:0] pulse_count
);
    logic [7:0] count_reg;
    logic [7:0] count_next;
    always_comb
    begin
        count_next = count_reg + {7'h00, irq_pulse};
    end
    always_ff @(posedge clk)
    begin
        count_reg <= rst ? 8'h00 : count_next;
    end
    assign pulse_count = count_reg;
endmodule : amis_irq_sink

//--- sim/async_mem_irq_status_bench.sv
// Bench of the interrupt status block.
// Assumes amis_irq, the sink model and the bound checker.
`timescale 1ns/10ps
module async_mem_irq_status_bench;
    typedef struct packed {
        logic we;
        logic [7:0] adr;
        logic [31:0] dat;
        logic [31:0] exp;
    } amis_row_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] memory_wait_input = 4'h0;
    logic ext_wait_stall = 1'b0;
    logic irq_pulse;
    logic irq_level;
    logic [7:0] pulses;
    logic [31:0] got;
    int n_fail = 0;
    int cmp_count = 0;
    // Writes are read back from the same word
    amis_row_type rows [9] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b0, 8'h04, 32'h0, 32'h0},
        '{1'b0, 8'h10, 32'h0, 32'h80}, '{1'b1, 8'h08, 32'h3D, 32'h3D},
        '{1'b1, 8'h08, 32'h0, 32'h3D}, '{1'b1, 8'h0C, 32'h3C, 32'h01},
        '{1'b1, 8'h10, 32'h05, 32'h05}, '{1'b1, 8'h0C, 32'h01, 32'h0},
        '{1'b0, 8'h1C, 32'h0, 32'h0}};
    always #2 clk = ~clk;
    amis_irq amis_irq_inst (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .memory_wait_input, .ext_wait_stall, .irq_pulse,
        .irq_level);
    amis_irq_sink amis_irq_sink_inst (.clk, .rst, .irq_pulse, .pulse_count(pulses));
    task automatic conclude;
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Ack and data are taken at the rising edge; only the watchdog ends a wait
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
        output logic [31:0] rd);
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
        do
        begin
            @(posedge clk);
        end
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : bus
    task automatic rise(input int lane);
        @(posedge clk);
        memory_wait_input[lane] <= 1'b1;
        repeat (6) @(posedge clk);
        memory_wait_input[lane] <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : rise
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            bus(rows[i].we, rows[i].adr, rows[i].dat, got);
            if (rows[i].we)
                bus(1'b0, rows[i].adr, 32'h0, got);
            check(got, rows[i].exp);
        end
        rise(0);
        bus(1'b0, 8'h04, 32'h0, got);
        check(got, 32'h0);
        bus(1'b1, 8'h00, 32'h0, got);
        bus(1'b0, 8'h00, 32'h0, got);
        check(got, 32'h04);
        bus(1'b1, 8'h00, 32'h04, got);
        bus(1'b0, 8'h00, 32'h0, got);
        check(got, 32'h0);
        check({24'h000000, pulses}, 32'h0);
        bus(1'b1, 8'h08, 32'h3D, got);
        for (int k = 0; k < 4; k++)
        begin
            rise(k);
            bus(1'b0, 8'h04, 32'h0, got);
            check(got, 32'h1 << (k + 2));
            bus(1'b1, 8'h04, got, got);
            bus(1'b0, 8'h00, 32'h0, got);
            check(got, 32'h0);
        end
        check({24'h000000, pulses}, 32'h4);
        bus(1'b0, 8'h14, 32'h0, got);
        check(got, 32'h3C);
        bus(1'b1, 8'h18, 32'h01, got);
        @(posedge clk);
        ext_wait_stall <= 1'b1;
        repeat (12) @(posedge clk);
        ext_wait_stall <= 1'b0;
        bus(1'b0, 8'h00, 32'h0, got);
        check(got, 32'h01);
        check({31'h0, irq_level}, 32'h1);
        bus(1'b0, 8'h14, 32'h0, got);
        @(negedge clk);
        check({31'h0, irq_level}, 32'h0);
        check({24'h000000, pulses}, 32'h5);
        // Pin edge reaches the flags at the edge that takes the W1C write
        @(posedge clk);
        memory_wait_input[0] <= 1'b1;
        @(posedge clk);
        bus(1'b1, 8'h00, 32'h04, got);
        memory_wait_input[0] <= 1'b0;
        bus(1'b0, 8'h00, 32'h0, got);
        check(got, 32'h05);
        bus(1'b0, 8'h04, 32'h0, got);
        check(got, 32'h05);
        check({24'h000000, pulses}, 32'h6);
        // Mid-run reset clears flags and enables and reloads the count with 0x80
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 8'h00, 32'h0, got);
        check(got, 32'h0);
        bus(1'b0, 8'h04, 32'h0, got);
        check(got, 32'h0);
        bus(1'b0, 8'h08, 32'h0, got);
        check(got, 32'h0);
        bus(1'b0, 8'h10, 32'h0, got);
        check(got, 32'h80);
        conclude();
    end
endmodule : async_mem_irq_status_bench
